/* File: sleep_cfg.svh */
`ifndef SLEEP_CFG_SVH
`define SLEEP_CFG_SVH
`define LEVEL_COUNT 4
`define LEVEL_W 2
`define DEEPEST_LEVEL 2'h3
`define FIRST_LEVEL 2'h0
`define TIME_W 24
`define MOTION_W 8
`define CHECK_TIME_NS 2900000
`define CLK_PERIOD_NS 5
`define CHECK_CYCLES (`CHECK_TIME_NS / `CLK_PERIOD_NS)
`define TIME_ZERO 24'h000000
`define TIME_ONE 24'h000001
`endif

/* File: sleep_pkg.sv */
package sleep_pkg;
  typedef enum logic [2:0] {
    ST_TRACK = 3'h0,
    ST_INACTIVE = 3'h1,
    ST_CHECK = 3'h3,
    ST_SHUTDOWN = 3'h2
  } mode_t;
endpackage

/* File: interval_timer.sv */
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module interval_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [`TIME_W-1:0] load_value,
  output logic expired
);
  logic [`TIME_W-1:0] count;
  logic [`TIME_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != `TIME_ZERO) begin
      next_count = count - `TIME_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TIME_ZERO;
    end else if (ce) begin
      count <= next_count;
    end
  end

  // Expiry is seen when the count reaches one so the terminal cycle is not wasted.
  // It does not look at load, because the parent derives load from expiry and would close a loop.
  assign expired = count == `TIME_ONE || count == `TIME_ZERO;
endmodule // interval_timer

/* File: motion_sleep_mode_sequencer.sv */
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module motion_sleep_mode_sequencer (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic SLEEP_ENABLE,
  input wire logic ENTER_SLEEP,
  input wire logic SHUTDOWN_REQ,
  input wire logic MOTION_VALID,
  input wire logic [`MOTION_W-1:0] MOTION_AMOUNT,
  input wire logic [`LEVEL_COUNT*`TIME_W-1:0] INACTIVE_TIME,
  input wire logic [`LEVEL_COUNT*`MOTION_W-1:0] MOTION_THRESHOLD,
  input wire logic [`LEVEL_COUNT*`TIME_W-1:0] DWELL_TIME,
  output logic SENSOR_ON,
  output logic TIMER_WAKE,
  output logic IN_SLEEP,
  output logic [`LEVEL_W-1:0] SLEEP_LEVEL,
  output logic CPU_HALT,
  output sleep_pkg::mode_t MODE
);
  import sleep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the level inputs from outside the clock domain.

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sleep_en;
  logic enter_sleep;
  logic shutdown_req;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else if (CLK_EN) begin
      sync_a <= {SHUTDOWN_REQ, ENTER_SLEEP, SLEEP_ENABLE};
      sync_b <= sync_a;
    end
  end

  assign sleep_en = sync_b[0];
  assign enter_sleep = sync_b[1];
  assign shutdown_req = sync_b[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Per-level parameter selection.

  function automatic logic [`TIME_W-1:0] pick_time(input logic [`LEVEL_COUNT*`TIME_W-1:0] vec,
                                                   input logic [`LEVEL_W-1:0] lvl);
    pick_time = vec[lvl*`TIME_W +: `TIME_W];
  endfunction

  logic [`MOTION_W-1:0] threshold_sel [`LEVEL_COUNT];
  genvar g;
  generate
    for (g = 0; g < `LEVEL_COUNT; g++) begin : g_thr
      assign threshold_sel[g] = MOTION_THRESHOLD[g*`MOTION_W +: `MOTION_W];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  mode_t mode;
  mode_t next_mode;
  logic [`LEVEL_W-1:0] level;
  logic [`LEVEL_W-1:0] next_level;
  logic [`TIME_W-1:0] check_count;
  logic [`TIME_W-1:0] next_check_count;
  logic wake_pulse;
  logic next_wake_pulse;
  logic motion_seen;
  logic next_motion_seen;

  logic inact_load;
  logic inact_expired;
  logic dwell_load;
  logic dwell_expired;

  interval_timer inactive_timer (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .load(inact_load),
    .load_value(pick_time(INACTIVE_TIME, level)),
    .expired(inact_expired)
  );

  // The dwell timer is loaded with the next level's dwell on each step.
  // It runs on the plain enable: tracking reloads it every cycle, so it only counts down in sleep and shutdown.
  // Gating it off in tracking would also block that reload and leave it expired on entry.
  interval_timer dwell_timer (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .load(dwell_load),
    .load_value(pick_time(DWELL_TIME, next_level)),
    .expired(dwell_expired)
  );

  always_comb begin
    next_mode = mode;
    next_level = level;
    next_check_count = check_count;
    next_wake_pulse = 1'b0;
    next_motion_seen = motion_seen;
    inact_load = 1'b0;
    dwell_load = 1'b0;
    case (mode)
      ST_TRACK: begin
        next_level = `FIRST_LEVEL;
        dwell_load = 1'b1;
        // Without sleep enabled the block leaves tracking only on a shutdown request.
        if (sleep_en && enter_sleep) begin
          next_mode = ST_INACTIVE;
          inact_load = 1'b1;
        end
      end
      ST_INACTIVE: begin
        if (!sleep_en) begin
          // Leaving on a disable is not a timer wake, so no wake pulse is given.
          next_mode = ST_TRACK;
        end else if (inact_expired) begin
          next_mode = ST_CHECK;
          next_check_count = `TIME_W'(`CHECK_CYCLES);
          next_motion_seen = 1'b0;
          next_wake_pulse = 1'b1;
        end
      end
      ST_CHECK: begin
        if (next_check_count != `TIME_ZERO) begin
          next_check_count = check_count - `TIME_ONE;
        end
        if (MOTION_VALID && MOTION_AMOUNT >= threshold_sel[level]) begin
          next_motion_seen = 1'b1;
        end
        if (!sleep_en) begin
          next_mode = ST_TRACK;
        end else if (check_count == `TIME_ONE) begin
          if (next_motion_seen) begin
            next_mode = ST_TRACK;
          end else begin
            next_mode = ST_INACTIVE;
            inact_load = 1'b1;
            // Stepping is automatic; the deepest level is held.
            if (dwell_expired && level != `DEEPEST_LEVEL) begin
              next_level = level + `LEVEL_W'(1);
              dwell_load = 1'b1;
            end
          end
        end
      end
      ST_SHUTDOWN: begin
        next_mode = ST_SHUTDOWN;
      end
      default: begin
        next_mode = ST_TRACK;
      end
    endcase
    // Shutdown can only be left by the asynchronous reset.
    if (shutdown_req) begin
      next_mode = ST_SHUTDOWN;
      next_wake_pulse = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode <= ST_TRACK;
      level <= `FIRST_LEVEL;
      check_count <= `TIME_ZERO;
      wake_pulse <= 1'b0;
      motion_seen <= 1'b0;
    end else if (CLK_EN) begin
      mode <= next_mode;
      level <= next_level;
      check_count <= next_check_count;
      wake_pulse <= next_wake_pulse;
      motion_seen <= next_motion_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SENSOR_ON <= 1'b1;
      TIMER_WAKE <= 1'b0;
      IN_SLEEP <= 1'b0;
      SLEEP_LEVEL <= `FIRST_LEVEL;
      CPU_HALT <= 1'b0;
      MODE <= ST_TRACK;
    end else if (CLK_EN) begin
      SENSOR_ON <= next_mode == ST_TRACK || next_mode == ST_CHECK;
      TIMER_WAKE <= next_wake_pulse;
      IN_SLEEP <= next_mode == ST_INACTIVE || next_mode == ST_CHECK;
      SLEEP_LEVEL <= next_level;
      CPU_HALT <= next_mode == ST_SHUTDOWN;
      MODE <= next_mode;
    end
  end
endmodule // motion_sleep_mode_sequencer

/* File: sleep_chk_sva.sv */
`timescale 1ns/1ps
module sleep_chk
  import sleep_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic SLEEP_ENABLE,
  input wire logic ENTER_SLEEP,
  input wire logic SHUTDOWN_REQ,
  input wire logic SENSOR_ON,
  input wire logic TIMER_WAKE,
  input wire logic CPU_HALT,
  input wire sleep_pkg::mode_t MODE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  a_sensor_power: assert property (SENSOR_ON == (MODE inside {ST_TRACK, ST_CHECK}))
    else $error("sensor power wrong");
  a_halt_flag: assert property (CPU_HALT == (MODE == ST_SHUTDOWN))
    else $error("halt flag wrong");
  a_shutdown_stays: assert property (MODE == ST_SHUTDOWN |=> MODE == ST_SHUTDOWN)
    else $error("left shutdown");
  a_wake_pulse: assert property (TIMER_WAKE && CLK_EN |=> !TIMER_WAKE)
    else $error("wake pulse too long");
  a_wake_cause: assert property ($rose(TIMER_WAKE) |-> MODE == ST_CHECK && $past(MODE) == ST_INACTIVE)
    else $error("wake without timer");
  // Four samples cover the two-stage input synchroniser plus the state edge.
  a_no_sleep_off: assert property ((!SLEEP_ENABLE && CLK_EN)[*4] |-> MODE != ST_INACTIVE)
    else $error("asleep while disabled");
  a_enter_sleep: assert property ((SLEEP_ENABLE && ENTER_SLEEP && !SHUTDOWN_REQ && CLK_EN)[*4]
    ##0 MODE == ST_TRACK |=> MODE == ST_INACTIVE)
    else $error("no sleep entry");
  a_check_len: assert property ($rose(MODE == ST_CHECK) ##0 (SLEEP_ENABLE && !SHUTDOWN_REQ && CLK_EN)[*8]
    |-> MODE == ST_CHECK)
    else $error("check too short");
  c_check: cover property (TIMER_WAKE);
  c_halt: cover property (CPU_HALT);
  c_sleep: cover property (MODE == ST_INACTIVE);
endmodule // sleep_chk
bind motion_sleep_mode_sequencer sleep_chk u_chk (.SYS_CLK, .RESET_N, .CLK_EN, .SLEEP_ENABLE,
  .ENTER_SLEEP, .SHUTDOWN_REQ, .SENSOR_ON, .TIMER_WAKE, .CPU_HALT, .MODE);

/* File: motion_sleep_mode_sequencer_test.sv */
`timescale 1ns/1ps
module motion_sleep_mode_sequencer_test;
  import sleep_pkg::*;
  typedef struct {logic se; logic en; logic [23:0] it; int w; mode_t m; logic s;} row_t;
  logic SYS_CLK = 0, RESET_N = 0, CLK_EN = 1, SE = 0, EN = 0, SD = 0;
  logic [23:0] it = 24'h000010;
  logic SENSOR_ON, TIMER_WAKE, IN_SLEEP, CPU_HALT;
  mode_t MODE;
  int errors = 0, total_checks = 0, cyc = 0, wakes = 0;
  row_t rows [4] = '{'{0, 1, 24'h000005, 20, ST_TRACK, 1}, '{1, 0, 24'h000005, 20, ST_TRACK, 1},
    '{1, 1, 24'h000064, 20, ST_INACTIVE, 0}, '{1, 1, 24'h00000A, 30, ST_CHECK, 1}};
  motion_sleep_mode_sequencer uut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .SLEEP_ENABLE(SE), .ENTER_SLEEP(EN), .SHUTDOWN_REQ(SD), .MOTION_VALID(1'b0),
    .MOTION_AMOUNT(8'h00), .INACTIVE_TIME({4{it}}), .MOTION_THRESHOLD(32'h01010101),
    .DWELL_TIME({4{24'hFFFFFF}}), .SENSOR_ON(SENSOR_ON), .TIMER_WAKE(TIMER_WAKE),
    .IN_SLEEP(IN_SLEEP), .SLEEP_LEVEL(), .CPU_HALT(CPU_HALT), .MODE(MODE));
  initial forever #2.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic rst();
    RESET_N = 0;
    step(10);
    RESET_N = 1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The full motion check lasts far beyond this ceiling, so no test waits one out.
  always @(posedge SYS_CLK) begin
    cyc++;
    if (TIMER_WAKE === 1'b1) wakes++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    foreach (rows[i]) begin
      {SE, EN, it} = {rows[i].se, rows[i].en, rows[i].it};
      rst();
      wakes = 0;
      step(rows[i].w);
      chk("mode", MODE, rows[i].m);
      chk("sensor", SENSOR_ON, rows[i].s);
    end
    chk("wakes", wakes, 1);
    chk("sleep", IN_SLEEP, 1);
    SE = 0;
    step(5);
    chk("disable", MODE, ST_TRACK);
    RESET_N = 0;
    step(1);
    chk("reset mode", MODE, ST_TRACK);
    chk("reset halt", CPU_HALT, 0);
    {SE, EN, CLK_EN} = 3'b110;
    step(10);
    RESET_N = 1;
    step(10);
    chk("frozen", MODE, ST_TRACK);
    CLK_EN = 1;
    step(6);
    chk("unfrozen", MODE, ST_INACTIVE);
    SD = 1;
    step(5);
    chk("halt", CPU_HALT, 1);
    {SD, SE} = 2'b00;
    step(10);
    chk("held", MODE, ST_SHUTDOWN);
    rst();
    step(1);
    chk("resumed", MODE, ST_TRACK);
    final_report();
  end
endmodule // motion_sleep_mode_sequencer_test
